/* File: rtl/swl_map.svh */
// Purpose: Constants for the serial wiper latch loader
// Assumes: Ten-bit word, two address bits then eight data bits, both MSB first
// Notes:   Definitions only
`ifndef SWL_MAP_SVH
`define SWL_MAP_SVH
`define SWL_WORD_BITS    10
`define SWL_DATA_BITS    8
`define SWL_ADDR_BITS    2
`define SWL_ADDR_MSB     9
`define SWL_ADDR_LSB     8
`define SWL_DATA_MSB     7
`define SWL_MIDSCALE     8'h80
`define SWL_ADDR_CH1     2'h0
`define SWL_ADDR_CH2     2'h1
`define SWL_ADDR_CH3     2'h2
`define SWL_ADDR_CH4     2'h3
`define SWL_CHANNELS     4
`endif

/* File: rtl/swl_pkg.sv */
// Purpose: Types for the serial wiper latch loader
// Assumes: swl_map.svh holds the numbers
// Notes:   Variant selects how many latches accept serial loads
`include "swl_map.svh"
package swl_pkg;
  typedef enum logic [2:0] {
    SWL_ONE  = 3'h1,
    SWL_TWO  = 3'h2,
    SWL_FOUR = 3'h4
  } swl_variant_type;
  typedef logic [`SWL_DATA_BITS-1:0] swl_code_type;
endpackage

/* File: rtl/swl_link_if.sv */
// Purpose: Carries one decoded load from the shifter to the latch bank
// Assumes: One core clock
// Notes:   loadPulse lasts one cycle
`include "swl_map.svh"
interface swl_link_if;
  import swl_pkg::*;
  logic                      loadPulse;
  logic [`SWL_ADDR_BITS-1:0] loadAddr;
  swl_code_type              loadData;
  modport shifter (output loadPulse, output loadAddr, output loadData);
  modport bank    (input loadPulse, input loadAddr, input loadData);
endinterface

/* File: rtl/swl_shifter.sv */
// Purpose: Ten-bit serial shift register with chip-select load strobe
// Assumes: Serial clock and chip select sampled in core_clk domain
// Notes:   Edges detected by comparing each live pin with its registered copy
`include "swl_map.svh"
module swl_shifter
  import swl_pkg::*;
(
  input  wire logic                     core_clk,
  input  wire logic                     rstn,
  input  wire logic                     serialClk,
  input  wire logic                     chipSelectN,
  input  wire logic                     serial_data_in,
  output logic                          farEndBit,
  swl_link_if.shifter                   link
);
  logic [`SWL_WORD_BITS-1:0] shift_q;
  logic [`SWL_WORD_BITS-1:0] shift_d;
  logic                      sclkPrev_q;
  logic                      csPrev_q;
  logic                      sclkRise;
  logic                      csRise;
  // ====================================================
  // Edge detection and shifting
  assign sclkRise = serialClk & ~sclkPrev_q;
  assign csRise   = chipSelectN & ~csPrev_q;
  always_comb begin
    shift_d = shift_q;
    if (sclkRise && !chipSelectN) begin
      shift_d = {shift_q[`SWL_WORD_BITS-2:0], serial_data_in};
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      shift_q    <= '0;
      sclkPrev_q <= 1'b0;
      csPrev_q   <= 1'b1;
    end else begin
      shift_q    <= shift_d;
      sclkPrev_q <= serialClk;
      csPrev_q   <= chipSelectN;
    end
  end
  // Bit leaving the far end feeds the daisy chain
  assign farEndBit      = shift_q[`SWL_WORD_BITS-1];
  assign link.loadPulse = csRise;
  assign link.loadAddr  = shift_q[`SWL_ADDR_MSB:`SWL_ADDR_LSB];
  assign link.loadData  = shift_q[`SWL_DATA_MSB:0];
endmodule

/* File: rtl/swl_top.sv */
// Purpose: Serial loader for up to four eight-bit wiper latches
// Assumes: Pins sampled as synchronous to core_clk; serial clock well below core_clk/2
// Notes:   Pins are oversampled, so the shift timing trails the pins by a cycle
`include "swl_map.svh"
module swl_top
  import swl_pkg::*;
#(
  parameter swl_variant_type VARIANT = SWL_FOUR
)
(
  input  wire logic                          core_clk,
  input  wire logic                          rstn,
  input  wire logic                          chipSelectN,
  input  wire logic                          serialClk,
  input  wire logic                          serial_data_in,
  input  wire logic                          midscale_reset_n,
  input  wire logic                          power_down_n,
  output logic                               serialDataOutO,
  output logic                               serialDataOutOe,
  output logic [`SWL_CHANNELS*`SWL_DATA_BITS-1:0] wiperCodes,
  output logic [`SWL_CHANNELS-1:0]           terminalAOpen
);
  swl_link_if link ();
  logic         farEndBit;
  swl_code_type latch_q [`SWL_CHANNELS];
  swl_code_type latch_d [`SWL_CHANNELS];
  logic         sdoOe_q;
  logic         sdoOe_d;
  logic         tAOpen_q;
  logic         tAOpen_d;

  // ====================================================
  // Address decode
  // Unpopulated channels never load, so a stray address is harmless
  function automatic logic chanExists(input logic [`SWL_ADDR_BITS-1:0] a);
    case (VARIANT)
      SWL_ONE:  chanExists = (a == `SWL_ADDR_CH1);
      SWL_TWO:  chanExists = (a == `SWL_ADDR_CH1) || (a == `SWL_ADDR_CH2);
      SWL_FOUR: chanExists = 1'b1;
      default:  chanExists = 1'b0;
    endcase
  endfunction

  swl_shifter u_shifter (
    .core_clk       (core_clk),
    .rstn           (rstn),
    .serialClk      (serialClk),
    .chipSelectN    (chipSelectN),
    .serial_data_in (serial_data_in),
    .farEndBit      (farEndBit),
    .link           (link)
  );

  // ====================================================
  // Wiper latches
  always_comb begin
    for (int i = 0; i < `SWL_CHANNELS; i++) begin
      latch_d[i] = latch_q[i];
      if (!midscale_reset_n) begin
        latch_d[i] = `SWL_MIDSCALE;
      end else if (link.loadPulse && chanExists(link.loadAddr)
                   && (link.loadAddr == i[`SWL_ADDR_BITS-1:0])) begin
        latch_d[i] = link.loadData;
      end
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `SWL_CHANNELS; i++) begin
        latch_q[i] <= `SWL_MIDSCALE;
      end
    end else begin
      for (int i = 0; i < `SWL_CHANNELS; i++) begin
        latch_q[i] <= latch_d[i];
      end
    end
  end

  // ====================================================
  // Shutdown and open-drain output
  always_comb begin
    tAOpen_d = ~power_down_n;
    sdoOe_d  = power_down_n & ~farEndBit;
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tAOpen_q <= 1'b0;
      sdoOe_q  <= 1'b0;
    end else begin
      tAOpen_q <= tAOpen_d;
      sdoOe_q  <= sdoOe_d;
    end
  end

  assign serialDataOutO  = 1'b0;
  assign serialDataOutOe = sdoOe_q;
  assign terminalAOpen   = {`SWL_CHANNELS{tAOpen_q}};
  always_comb begin
    for (int i = 0; i < `SWL_CHANNELS; i++) begin
      wiperCodes[i*`SWL_DATA_BITS +: `SWL_DATA_BITS] = latch_q[i];
    end
  end
endmodule

/* File: tb/swl_top_chk.sv */
// Purpose: Port assertions for swl_top
// Assumes: Registered outputs trail their cause by one cycle
// Notes:   Bound to every swl_top instance
module swl_top_chk (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        chipSelectN,
  input wire logic        midscale_reset_n,
  input wire logic        power_down_n,
  input wire logic        serialDataOutO,
  input wire logic        serialDataOutOe,
  input wire logic [31:0] wiperCodes,
  input wire logic [3:0]  terminalAOpen
);
  timeunit 1ns;
  timeprecision 1ns;
  // ======
  // Checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_mid_force: assert property (!midscale_reset_n |=> wiperCodes == {4{8'h80}})
    else $error("latches not midscale");
  a_pd_open: assert property (!power_down_n |=> terminalAOpen == 4'hf)
    else $error("terminal A not open");
  a_pd_close: assert property (power_down_n |=> terminalAOpen == 4'h0)
    else $error("terminal A open");
  a_open_equal: assert property (terminalAOpen == {4{terminalAOpen[0]}})
    else $error("channels differ in shutdown");
  a_od_low: assert property (serialDataOutO == 1'b0)
    else $error("output drives high");
  a_pd_sdo_off: assert property (!power_down_n |=> !serialDataOutOe)
    else $error("output active in shutdown");
  // Loads only follow a chip select rise, so idle select must freeze latches
  a_cs_hold: assert property (chipSelectN && $past(chipSelectN) && midscale_reset_n
    && $past(midscale_reset_n) |=> $stable(wiperCodes)) else $error("latch moved");
  a_load_cause: assert property ($changed(wiperCodes) && $past(midscale_reset_n)
    |-> $past(chipSelectN) && !$past(chipSelectN, 2)) else $error("stray load");
endmodule
bind swl_top swl_top_chk u_chk (.core_clk, .rstn, .chipSelectN, .midscale_reset_n,
  .power_down_n, .serialDataOutO, .serialDataOutOe, .wiperCodes, .terminalAOpen);

/* File: tb/swl_host.sv */
// Purpose: Host controller driving the three-wire load interface
// Assumes: Serial clock held high two core cycles and low three core cycles per bit
// Notes:   Serial clock stands low between frames
module swl_host (
  input  wire logic core_clk,
  output logic      chipSelectN    = 1'b1,
  output logic      serialClk      = 1'b0,
  output logic      serial_data_in = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // =====
  // Frame
  task automatic send(input logic [9:0] w, input logic csHold);
    @(posedge core_clk) chipSelectN <= csHold;
    for (int i = 9; i >= 0; i--) begin
      @(posedge core_clk) serial_data_in <= w[i];
      @(posedge core_clk) serialClk <= 1'b1;
      @(posedge core_clk);
      @(posedge core_clk) serialClk <= 1'b0;
      serial_data_in <= ~w[i];
      @(posedge core_clk);
    end
    @(posedge core_clk) chipSelectN <= 1'b1;
  endtask
endmodule

/* File: tb/swl_top_bench.sv */
// Purpose: Self-checking bench for swl_top
// Assumes: Four-channel variant, with a single-channel copy on the same wires
// Notes:   Serial output line modelled with a pull-up
module swl_top_bench;
  import swl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 0, rstn = 0, midscale_reset_n = 1, power_down_n = 1;
  logic        chipSelectN, serialClk, serial_data_in, serialDataOutO, serialDataOutOe;
  logic [31:0] wiperCodes, expCodes, wiperOne, expOne;
  logic [3:0]  terminalAOpen;
  int          n_mismatch = 0, tests_run = 0, cyc = 0;
  wire         sdoLine = serialDataOutOe ? serialDataOutO : 1'b1;
  always #10 core_clk = ~core_clk;
  swl_host host (.core_clk, .chipSelectN, .serialClk, .serial_data_in);
  swl_top #(.VARIANT(SWL_FOUR)) dut (.core_clk, .rstn, .chipSelectN, .serialClk,
    .serial_data_in, .midscale_reset_n, .power_down_n, .serialDataOutO,
    .serialDataOutOe, .wiperCodes, .terminalAOpen);
  // Single-channel variant shares the wires; only address 00 may load it
  swl_top #(.VARIANT(SWL_ONE)) dutOne (.core_clk, .rstn, .chipSelectN, .serialClk,
    .serial_data_in, .midscale_reset_n, .power_down_n, .serialDataOutO(),
    .serialDataOutOe(), .wiperCodes(wiperOne), .terminalAOpen());
  // =====
  // Tasks
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task load(input logic [9:0] w);
    host.send(w, 1'b0);
    expCodes[8*w[9:8] +: 8] = w[7:0];
    if (w[9:8] == 2'h0) expOne[7:0] = w[7:0];
    repeat (2) @(posedge core_clk);
    #1 chk("codes", expCodes, wiperCodes);
    chk("one", expOne, wiperOne);
    chk("sdo", 32'(power_down_n ? w[9] : 1'b1), 32'(sdoLine));
  endtask
  task t_channels;
    for (int a = 0; a < 4; a++) load({2'(a), 8'(a * 51 + 7)});
  endtask
  task t_stray;
    host.send(10'h3ff, 1'b1);
    repeat (2) @(posedge core_clk);
    #1 chk("stray", expCodes, wiperCodes);
  endtask
  task t_shutdown;
    @(posedge core_clk) power_down_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk("open", 32'hf, 32'(terminalAOpen));
    load(10'h2a5);
    @(posedge core_clk) power_down_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 chk("closed", 32'h0, 32'(terminalAOpen));
  endtask
  task t_midscale;
    @(posedge core_clk) midscale_reset_n <= 1'b0;
    expCodes = {4{8'h80}};
    expOne   = {4{8'h80}};
    repeat (2) @(posedge core_clk);
    #1 chk("mid", expCodes, wiperCodes);
    chk("mid one", expOne, wiperOne);
    @(posedge core_clk) midscale_reset_n <= 1'b1;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      stop_test;
    end
  end
  initial begin
    expCodes = {4{8'h80}};
    expOne   = {4{8'h80}};
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    #1 chk("reset", expCodes, wiperCodes);
    t_channels;
    t_stray;
    t_shutdown;
    t_midscale;
    load(10'h0c3);
    stop_test;
  end
endmodule
